// file: hdl/swti_fifo.v
`timescale 1ns/10ps
module swti_fifo #(
  parameter W = 56,
  parameter D = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Fill side
  input wire wr_valid,
  output wire wr_ready,
  input wire [W-1:0] wr_data,
  // Drain side
  output wire rd_valid,
  input wire rd_ready,
  output wire [W-1:0] rd_data
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] cnt_reg;
  reg full_reg;
  reg empty_reg;
  wire push;
  wire pop;
  reg [AW:0] cnt_next;

  assign wr_ready = !full_reg;
  assign rd_valid = !empty_reg;
  assign rd_data = mem_reg[rptr_reg];
  assign push = wr_valid && !full_reg;
  assign pop = rd_ready && !empty_reg;

  always @* begin
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  always @(posedge clk) begin
    if (push)
      mem_reg[wptr_reg] <= wr_data;
  end

  always @(posedge clk) begin
    if (srst) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (push)
        wptr_reg <= (wptr_reg == D - 1) ? {AW{1'b0}} : wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= (rptr_reg == D - 1) ? {AW{1'b0}} : rptr_reg + 1'b1;
      cnt_reg <= cnt_next;
      full_reg <= (cnt_next == D);
      empty_reg <= (cnt_next == {(AW+1){1'b0}});
    end
  end
endmodule // swti_fifo

// file: hdl/swti_map.vh
`ifndef SWTI_MAP_VH
`define SWTI_MAP_VH

// Packet classes
`define SWTI_CLS_POSTED 2'h0
`define SWTI_CLS_NONPOSTED 2'h1
`define SWTI_CLS_COMPLETION 2'h2
`define SWTI_CLS_INSERTED 2'h3

// Report codes
`define SWTI_REP_NONE 2'h0
`define SWTI_REP_COR 2'h1
`define SWTI_REP_NONFATAL 2'h2
`define SWTI_REP_FATAL 2'h3

// Reset values of the control bits and of the reporting fields, two bits per class
`define SWTI_TO_REPORT_RST 8'h82
`define SWTI_PAR_REPORT_RST 2'h2
`define SWTI_TO_CTRL_RST 1'h0
`define SWTI_PAR_DIS_RST 1'h0

// Header dword 0 fields
`define SWTI_HDR_FMT_HI 31
`define SWTI_HDR_TYPE_HI 28
`define SWTI_HDR_RO_BIT 13
`define SWTI_HDR_NS_BIT 12
`define SWTI_HDR_LEN_HI 9

// Fifo entry layout
`define SWTI_E_DATA_LO 0
`define SWTI_E_PAR 32
`define SWTI_E_SOP 33
`define SWTI_E_EOP 34
`define SWTI_E_CLS_LO 35
`define SWTI_E_BCAST 37
`define SWTI_E_CONS 38
`define SWTI_E_TS_LO 39
`define SWTI_ENTRY_W 56

// Timing
`define SWTI_CLK_MHZ 40
`define SWTI_AGE_TICK_US 1000
`define SWTI_AGE_LIMIT_S 64
`define SWTI_TICK_CYC (`SWTI_AGE_TICK_US * `SWTI_CLK_MHZ)
`define SWTI_AGE_LIMIT_TICKS (`SWTI_AGE_LIMIT_S * 1000000 / `SWTI_AGE_TICK_US)

`endif

// file: hdl/swti_port_integrity.v
// Overview of operation
// RQ1 - Drop any class packet reaching queue head when older than 64 seconds.
// RQ2 - Age discard on after reset; setting the control bit turns it off.
// RQ3 - Each time-out discard sets the status flag of its class.
// RQ4 - Each discard bumps a saturating class counter; reading clears it.
// RQ5 - Per-class report code, gated by system-error and severity enables.
// RQ6 - Time-out message only on flag rising; none again until cleared.
// RQ7 - After reset posted and inserted report non-fatal; others silent.
// RQ8 - Broadcast packet timing out mid-transfer is abandoned partway.
// RQ9 - Even parity computed over each received 32-bit dword.
// RQ10 - Content changes adjust parity incrementally, never regenerate it.
// RQ11 - Egress checks parity alongside outgoing link CRC generation.
// RQ12 - Egress parity error nullifies: inverted link CRC and EDB ending.
// RQ13 - Parity error sets status flag, bumps saturating read-clear counter.
// RQ14 - Packet memories hold even parity per dword, carried with data.
// RQ15 - Parity report code; message only on flag rising, once until cleared.
// RQ16 - Checking-disable bit stops checks; generation always stays on.
// RQ17 - Test bit plus matching header length inverts parity of every dword.
// RQ18 - After reset parity checking is on and reports non-fatal.
// RQ19 - Created packets get parity; consumed packets checked and dropped on error.
// RQ20 - Force relaxed-ordering overwrites the attribute with programmed value.
// RQ21 - Relaxed-ordering rewrite skips config, I/O, messages; memory writes rewritten.
// RQ22 - Force no-snoop overwrites the attribute with programmed value.
// RQ23 - No-snoop rewrite skips config, I/O, messages; memory writes rewritten.
// RQ24 - Each queued packet carries an arrival timestamp for the age check.
`timescale 1ns/10ps
`include "swti_map.vh"
module swti_port_integrity #(
  parameter TICK_CYC = `SWTI_TICK_CYC,
  parameter AGE_LIMIT_TICKS = `SWTI_AGE_LIMIT_TICKS,
  parameter TS_W = 17,
  parameter CNT_W = 8,
  parameter DEPTH = 16,
  parameter DEPTH_AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Received packet stream from the data link layer
  input wire in_valid,
  output wire in_ready,
  input wire [31:0] in_data,
  input wire in_sop,
  input wire in_eop,
  input wire [1:0] in_class,
  input wire in_bcast,
  input wire in_consume,
  // Egress packet stream toward the link
  output wire out_valid,
  input wire out_ready,
  output wire [31:0] out_data,
  output wire out_par,
  output wire out_sop,
  output wire out_eop,
  output wire out_lcrc_invert,
  output wire out_edb,
  output wire out_consume,
  output wire out_discard,
  // Configuration load
  input wire cfg_wr,
  input wire cfg_timeout_control_bit,
  input wire [7:0] cfg_timeout_report,
  input wire cfg_parity_check_disable,
  input wire [1:0] cfg_parity_report,
  // Test and rewrite controls
  input wire force_bad_parity,
  input wire [9:0] bad_parity_length,
  input wire force_relaxed_ordering,
  input wire relaxed_ordering_value,
  input wire force_no_snoop,
  input wire no_snoop_value,
  // Error reporting enables
  input wire system_error_enable,
  input wire correctable_report_enable,
  input wire nonfatal_report_enable,
  input wire fatal_report_enable,
  input wire unsupported_req_report_enable,
  // Status and counters
  output wire [3:0] timeout_status,
  input wire [3:0] timeout_status_clr,
  output wire [4*CNT_W-1:0] timeout_count,
  input wire [3:0] timeout_count_rd,
  output wire parity_error_flag,
  input wire parity_error_flag_clr,
  output wire [CNT_W-1:0] parity_error_counter,
  input wire parity_error_counter_rd,
  // Error message request
  output wire err_msg_valid,
  output wire [1:0] err_msg_type
);
  function rewrite_ok;
    input [7:0] fmt_type;
    begin
      // Config 0010x, I/O 00010, messages 10xxx are not rewritten
      rewrite_ok = !((fmt_type[4:1] == 4'h2) || (fmt_type[4:0] == 5'h02)
        || (fmt_type[4:3] == 2'h2));
    end
  endfunction

  function rep_gate;
    input [1:0] code;
    begin
      case (code)
        `SWTI_REP_COR: rep_gate = correctable_report_enable;
        `SWTI_REP_NONFATAL: rep_gate = nonfatal_report_enable || system_error_enable
          || unsupported_req_report_enable;
        `SWTI_REP_FATAL: rep_gate = fatal_report_enable || system_error_enable;
        default: rep_gate = 1'b0;
      endcase
    end
  endfunction

  // Configuration registers
  reg timeout_control_reg;
  reg [7:0] timeout_report_ctrl_reg;
  reg parity_control_reg;
  reg [1:0] parity_report_ctrl_reg;

  always @(posedge clk) begin
    if (srst) begin
      timeout_control_reg <= `SWTI_TO_CTRL_RST; // RQ2
      timeout_report_ctrl_reg <= `SWTI_TO_REPORT_RST; // RQ7
      parity_control_reg <= `SWTI_PAR_DIS_RST; // RQ18
      parity_report_ctrl_reg <= `SWTI_PAR_REPORT_RST; // RQ18
    end else if (cfg_wr) begin
      timeout_control_reg <= cfg_timeout_control_bit;
      timeout_report_ctrl_reg <= cfg_timeout_report;
      parity_control_reg <= cfg_parity_check_disable;
      parity_report_ctrl_reg <= cfg_parity_report;
    end
  end

  // Age time base
  reg [31:0] tick_cnt_reg;
  reg [TS_W-1:0] now_reg;

  always @(posedge clk) begin
    if (srst) begin
      tick_cnt_reg <= 32'h0;
      now_reg <= {TS_W{1'b0}};
    end else if (tick_cnt_reg == TICK_CYC - 1) begin
      tick_cnt_reg <= 32'h0;
      now_reg <= now_reg + 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // Ingress parity generation and attribute rewrite
  reg bad_pkt_reg;
  reg cur_bad;
  reg gen_par;
  reg elig;
  reg [31:0] wr_dw;
  reg wr_par;
  wire fifo_wr_ready;
  wire accept;
  wire [`SWTI_ENTRY_W-1:0] wr_entry;

  assign accept = in_valid && fifo_wr_ready;

  always @* begin
    cur_bad = in_sop ? (force_bad_parity
      && (in_data[`SWTI_HDR_LEN_HI:0] == bad_parity_length)) : bad_pkt_reg; // RQ17
    gen_par = (^in_data) ^ cur_bad; // RQ9 RQ19
    elig = in_sop && rewrite_ok(in_data[`SWTI_HDR_FMT_HI:24]);
    wr_dw = in_data;
    if (elig && force_relaxed_ordering)
      wr_dw[`SWTI_HDR_RO_BIT] = relaxed_ordering_value; // RQ20 RQ21
    if (elig && force_no_snoop)
      wr_dw[`SWTI_HDR_NS_BIT] = no_snoop_value; // RQ22 RQ23
    wr_par = gen_par ^ (wr_dw[`SWTI_HDR_RO_BIT] ^ in_data[`SWTI_HDR_RO_BIT])
      ^ (wr_dw[`SWTI_HDR_NS_BIT] ^ in_data[`SWTI_HDR_NS_BIT]); // RQ10
  end

  always @(posedge clk) begin
    if (srst)
      bad_pkt_reg <= 1'b0;
    else if (accept && in_sop)
      bad_pkt_reg <= cur_bad && !in_eop; // RQ17
  end

  assign wr_entry = {now_reg, in_consume, in_bcast, in_class, in_eop, in_sop,
    wr_par, wr_dw}; // RQ14 RQ24

  // Packet queue
  wire fifo_rd_valid;
  wire fifo_rd_ready;
  wire [`SWTI_ENTRY_W-1:0] rd_entry;

  swti_fifo #(
    .W(`SWTI_ENTRY_W),
    .D(DEPTH),
    .AW(DEPTH_AW)
  ) u_ingress_packet_buffer (
    .clk(clk),
    .srst(srst),
    .wr_valid(in_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(wr_entry),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(rd_entry)
  );

  assign in_ready = fifo_wr_ready;

  // Queue head decode
  wire [31:0] h_data = rd_entry[31:`SWTI_E_DATA_LO];
  wire h_par = rd_entry[`SWTI_E_PAR];
  wire h_sop = rd_entry[`SWTI_E_SOP];
  wire h_eop = rd_entry[`SWTI_E_EOP];
  wire [1:0] h_cls = rd_entry[`SWTI_E_CLS_LO+1:`SWTI_E_CLS_LO];
  wire h_bcast = rd_entry[`SWTI_E_BCAST];
  wire h_cons = rd_entry[`SWTI_E_CONS];
  wire [TS_W-1:0] h_ts = rd_entry[`SWTI_E_TS_LO+TS_W-1:`SWTI_E_TS_LO];
  wire [TS_W-1:0] h_age = now_reg - h_ts;
  wire h_aged = h_age > AGE_LIMIT_TICKS[TS_W-1:0]; // RQ1 RQ24

  // Egress stage
  reg out_valid_reg;
  reg [31:0] out_data_reg;
  reg out_par_reg;
  reg out_sop_reg;
  reg out_eop_reg;
  reg out_lcrc_invert_reg;
  reg out_edb_reg;
  reg out_consume_reg;
  reg out_discard_reg;
  reg drop_reg;
  reg in_pkt_reg;
  reg err_acc_reg;

  wire can_load = !out_valid_reg || out_ready;
  wire take = fifo_rd_valid && can_load;
  wire word_err = (^h_data) ^ h_par; // RQ11
  wire pkt_err = (err_acc_reg || word_err) && !parity_control_reg; // RQ16
  wire age_hit = take && !drop_reg && !timeout_control_reg && h_aged
    && (h_sop || (h_bcast && in_pkt_reg)); // RQ1 RQ2 RQ8
  wire emit = take && !drop_reg && !age_hit;
  wire par_event = emit && h_eop && pkt_err; // RQ13
  wire [3:0] to_event = age_hit ? (4'h1 << h_cls) : 4'h0; // RQ3

  assign fifo_rd_ready = can_load;

  always @(posedge clk) begin
    if (srst) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 32'h0;
      out_par_reg <= 1'b0;
      out_sop_reg <= 1'b0;
      out_eop_reg <= 1'b0;
      out_lcrc_invert_reg <= 1'b0;
      out_edb_reg <= 1'b0;
      out_consume_reg <= 1'b0;
      out_discard_reg <= 1'b0;
      drop_reg <= 1'b0;
      in_pkt_reg <= 1'b0;
      err_acc_reg <= 1'b0;
    end else begin
      if (take && drop_reg) begin
        drop_reg <= !h_eop;
        if (can_load)
          out_valid_reg <= 1'b0;
      end else if (age_hit) begin
        drop_reg <= !h_eop;
        in_pkt_reg <= 1'b0;
        err_acc_reg <= 1'b0;
        out_valid_reg <= !h_sop;
        // Abandoned broadcast tail closes as a nullified packet, or with out_discard if consumed
        out_data_reg <= h_data; // RQ8
        out_par_reg <= h_par;
        out_sop_reg <= 1'b0;
        out_eop_reg <= 1'b1;
        out_lcrc_invert_reg <= !h_cons;
        out_edb_reg <= !h_cons;
        out_consume_reg <= h_cons;
        out_discard_reg <= h_cons;
      end else if (emit) begin
        out_valid_reg <= 1'b1;
        out_data_reg <= h_data;
        out_par_reg <= h_par; // RQ14
        out_sop_reg <= h_sop;
        out_eop_reg <= h_eop;
        out_consume_reg <= h_cons;
        out_lcrc_invert_reg <= h_eop && pkt_err && !h_cons; // RQ12
        out_edb_reg <= h_eop && pkt_err && !h_cons; // RQ12
        out_discard_reg <= h_eop && pkt_err && h_cons; // RQ19
        in_pkt_reg <= !h_eop;
        err_acc_reg <= h_eop ? 1'b0 : (err_acc_reg || word_err);
      end else if (can_load) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign out_par = out_par_reg;
  assign out_sop = out_sop_reg;
  assign out_eop = out_eop_reg;
  assign out_lcrc_invert = out_lcrc_invert_reg;
  assign out_edb = out_edb_reg;
  assign out_consume = out_consume_reg;
  assign out_discard = out_discard_reg;

  // Status flags, set wins over clear
  reg [3:0] timeout_status_reg;
  reg parity_status_reg;
  wire [3:0] to_rise = to_event & ~timeout_status_reg; // RQ6
  wire par_rise = par_event && !parity_status_reg; // RQ15

  always @(posedge clk) begin
    if (srst) begin
      timeout_status_reg <= 4'h0;
      parity_status_reg <= 1'b0;
    end else begin
      timeout_status_reg <= (timeout_status_reg & ~timeout_status_clr) | to_event; // RQ3
      parity_status_reg <= (parity_status_reg && !parity_error_flag_clr)
        || par_event; // RQ13
    end
  end

  assign timeout_status = timeout_status_reg;
  assign parity_error_flag = parity_status_reg;

  // Saturating read-clear counters
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_to_cnt
      reg [CNT_W-1:0] cnt_reg;
      always @(posedge clk) begin
        if (srst)
          cnt_reg <= {CNT_W{1'b0}};
        else if (timeout_count_rd[gi])
          cnt_reg <= {{(CNT_W-1){1'b0}}, to_event[gi]}; // RQ4
        else if (to_event[gi] && !(&cnt_reg))
          cnt_reg <= cnt_reg + 1'b1; // RQ4
      end
      assign timeout_count[gi*CNT_W +: CNT_W] = cnt_reg;
    end
  endgenerate

  reg [CNT_W-1:0] parity_count_reg;

  always @(posedge clk) begin
    if (srst)
      parity_count_reg <= {CNT_W{1'b0}};
    else if (parity_error_counter_rd)
      parity_count_reg <= {{(CNT_W-1){1'b0}}, par_event}; // RQ13
    else if (par_event && !(&parity_count_reg))
      parity_count_reg <= parity_count_reg + 1'b1; // RQ13
  end

  assign parity_error_counter = parity_count_reg;

  // Error message queue, one message per rising flag whose report code passes its enables
  reg [4:0] pend_reg;
  reg [4:0] pend_set;
  reg [4:0] pend_take;
  reg [9:0] codes;
  reg [1:0] pick_code;
  reg found;
  reg err_msg_valid_reg;
  reg [1:0] err_msg_type_reg;
  integer k;

  always @* begin
    codes = {parity_report_ctrl_reg, timeout_report_ctrl_reg};
    pend_set = 5'h0;
    pend_take = 5'h0;
    pick_code = `SWTI_REP_NONE;
    found = 1'b0;
    for (k = 0; k < 5; k = k + 1) begin
      if ((k < 4 ? to_rise[k] : par_rise) && rep_gate(codes[2*k +: 2]))
        pend_set[k] = 1'b1; // RQ5 RQ6 RQ15
      if (pend_reg[k] && !found) begin
        found = 1'b1;
        pend_take[k] = 1'b1;
        pick_code = codes[2*k +: 2];
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pend_reg <= 5'h0;
      err_msg_valid_reg <= 1'b0;
      err_msg_type_reg <= `SWTI_REP_NONE;
    end else begin
      pend_reg <= (pend_reg & ~pend_take) | pend_set;
      err_msg_valid_reg <= found;
      if (found)
        err_msg_type_reg <= pick_code; // RQ5
    end
  end

  assign err_msg_valid = err_msg_valid_reg;
  assign err_msg_type = err_msg_type_reg;
endmodule // swti_port_integrity

// file: tb/swti_link_model.sv
`timescale 1ns/10ps
module swti_link_model (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Pacing
  input wire hold,
  input wire slow,
  // Egress stream
  input wire out_valid,
  output logic out_ready,
  input wire [31:0] out_data,
  input wire out_par,
  input wire out_lcrc_invert,
  input wire out_sop,
  input wire out_consume,
  input wire out_edb,
  input wire out_discard
);
  logic tgl_reg;
  logic [31:0] d [0:127];
  logic p [0:127];
  logic nl [0:127];
  logic [3:0] fl [0:127];
  int n;

  assign out_ready = !hold && (!slow || tgl_reg);

  always @(posedge clk) begin
    tgl_reg <= srst ? 1'b0 : !tgl_reg;
    if (srst) begin
      n <= 0;
    end else if (out_valid && out_ready) begin
      // Nullified words kept so the bench can judge them
      d[n] <= out_data;
      p[n] <= out_par;
      nl[n] <= out_lcrc_invert;
      fl[n] <= {out_sop, out_consume, out_edb, out_discard};
      n <= n + 1;
    end
  end
endmodule // swti_link_model

// file: tb/swti_port_integrity_assertions.sv
`timescale 1ns/10ps
module swti_chk #(
  parameter CNT_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Egress stream
  input wire out_valid,
  input wire out_ready,
  input wire [31:0] out_data,
  input wire out_par,
  input wire out_eop,
  input wire out_lcrc_invert,
  input wire out_edb,
  // Status and counters
  input wire [3:0] timeout_status,
  input wire [3:0] timeout_status_clr,
  input wire [4*CNT_W-1:0] timeout_count,
  input wire [3:0] timeout_count_rd,
  input wire parity_error_flag,
  input wire parity_error_flag_clr,
  input wire [CNT_W-1:0] parity_error_counter,
  input wire parity_error_counter_rd,
  // Error message request
  input wire err_msg_valid,
  input wire [1:0] err_msg_type
);
  logic [CNT_W-1:0] pec_prev_reg;

  always @(posedge clk) begin
    pec_prev_reg <= parity_error_counter;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  nullify_pair_a: assert property (out_valid && out_lcrc_invert |-> out_edb && out_eop)
    else $error("nullify without edb at eop");
  stall_hold_a: assert property (out_valid && !out_ready
    |=> out_valid && $stable({out_data, out_par}))
    else $error("stalled word or parity changed");
  msg_kind_a: assert property (err_msg_valid |-> err_msg_type != 2'h0)
    else $error("message sent with code none");
  msg_cause_a: assert property (err_msg_valid |-> $past(|timeout_status || parity_error_flag))
    else $error("message without a status flag");
  par_rise_a: assert property ($rose(parity_error_flag) |-> parity_error_counter != 0)
    else $error("parity flag set without count");
  par_sticky_a: assert property (parity_error_flag && !parity_error_flag_clr |=> parity_error_flag)
    else $error("parity flag dropped uncleared");
  to_sticky_a: assert property (timeout_status[0] && !timeout_status_clr[0] |=> timeout_status[0])
    else $error("timeout flag dropped uncleared");
  rd_clear_a: assert property (parity_error_counter_rd |=> parity_error_counter <= 1)
    else $error("parity count not cleared by read");
  to_rd_clear_a: assert property (timeout_count_rd[0] |=> timeout_count[CNT_W-1:0] <= 1)
    else $error("timeout count not cleared by read");
  par_step_a: assert property (!parity_error_counter_rd |=> parity_error_counter - pec_prev_reg <= 1)
    else $error("parity count jumped or wrapped");

  cover property (out_valid && out_lcrc_invert);
  cover property ($rose(timeout_status[3]));
  cover property (err_msg_valid && err_msg_type == 2'h2);
endmodule // swti_chk

bind swti_port_integrity swti_chk #(.CNT_W(CNT_W)) chk_i (.clk, .srst, .out_valid, .out_ready,
  .out_data, .out_par, .out_eop, .out_lcrc_invert, .out_edb, .timeout_status, .timeout_status_clr,
  .timeout_count, .timeout_count_rd, .parity_error_flag, .parity_error_flag_clr,
  .parity_error_counter, .parity_error_counter_rd, .err_msg_valid, .err_msg_type);

// file: tb/swti_port_integrity_tb_top.sv
`timescale 1ns/10ps
module swti_port_integrity_tb_top;
  logic clk, srst, in_valid, in_sop, in_eop, in_bcast, in_consume, cfg_wr, hold, slow;
  logic cfg_timeout_control_bit, cfg_parity_check_disable, force_bad_parity;
  logic force_relaxed_ordering, relaxed_ordering_value, force_no_snoop, no_snoop_value;
  logic system_error_enable, correctable_report_enable, nonfatal_report_enable;
  logic fatal_report_enable, unsupported_req_report_enable, parity_error_flag_clr;
  logic parity_error_counter_rd;
  logic [31:0] in_data;
  logic [1:0] in_class, cfg_parity_report, msg_t;
  logic [7:0] cfg_timeout_report;
  logic [9:0] bad_parity_length;
  logic [3:0] timeout_status_clr, timeout_count_rd;
  wire in_ready, out_valid, out_ready, out_par, out_sop, out_eop, out_lcrc_invert, out_edb;
  wire out_consume, out_discard, parity_error_flag, err_msg_valid;
  wire [31:0] out_data, timeout_count;
  wire [3:0] timeout_status;
  wire [7:0] parity_error_counter;
  wire [1:0] err_msg_type;
  int fails = 0, n_tests = 0, n_msg = 0;

  swti_port_integrity #(.TICK_CYC(4), .AGE_LIMIT_TICKS(3)) dut (.clk, .srst, .in_valid,
    .in_ready, .in_data, .in_sop, .in_eop, .in_class, .in_bcast, .in_consume, .out_valid,
    .out_ready, .out_data, .out_par, .out_sop, .out_eop, .out_lcrc_invert, .out_edb,
    .out_consume, .out_discard, .cfg_wr, .cfg_timeout_control_bit, .cfg_timeout_report,
    .cfg_parity_check_disable, .cfg_parity_report, .force_bad_parity, .bad_parity_length,
    .force_relaxed_ordering, .relaxed_ordering_value, .force_no_snoop, .no_snoop_value,
    .system_error_enable, .correctable_report_enable, .nonfatal_report_enable,
    .fatal_report_enable, .unsupported_req_report_enable, .timeout_status,
    .timeout_status_clr, .timeout_count, .timeout_count_rd, .parity_error_flag,
    .parity_error_flag_clr, .parity_error_counter, .parity_error_counter_rd, .err_msg_valid,
    .err_msg_type);
  swti_link_model lk (.clk, .srst, .hold, .slow, .out_valid, .out_ready, .out_data,
    .out_par, .out_lcrc_invert, .out_sop, .out_consume, .out_edb, .out_discard);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (err_msg_valid === 1'b1) begin
      n_msg <= n_msg + 1;
      msg_t <= err_msg_type;
    end
  end

  task automatic finish_test;
    $display("Tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [31:0] h, input logic [1:0] c, input int k);
    for (int i = 0; i < k; i++) begin
      @(negedge clk);
      in_valid = 1'b1;
      in_data = (i == 0) ? h : 32'hC3A5_0000 + i;
      in_sop = (i == 0);
      in_eop = (i == k - 1);
      in_class = c;
      while (!in_ready) @(negedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask

  task automatic wait_n(input int k);
    int t = 0;
    while (lk.n < k && t < 200) begin
      @(negedge clk);
      t++;
    end
    repeat (4) @(negedge clk);
  endtask

  task automatic cfg(input logic off, input logic dis);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_timeout_control_bit = off;
    cfg_parity_check_disable = dis;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask

  // Second packet, or a broadcast packet's second word, waits at the head behind the stalled first word
  task automatic t_age(input logic [1:0] c, input logic off, input logic bc);
    int b = lk.n;
    int m = n_msg;
    logic rep = !off && (c == 2'h0 || c == 2'h3);
    hold = 1'b1;
    in_bcast = bc;
    send(32'h4000_0001, c, bc ? 3 : 1);
    in_bcast = 1'b0;
    if (!bc) send(32'h4000_0001, c, 1);
    repeat (30) @(negedge clk);
    hold = 1'b0;
    wait_n(b + 2);
    chk(lk.n, b + ((off || bc) ? 2 : 1));
    if (bc) chk({lk.nl[b + 1], lk.fl[b + 1]}, 5'h12);
    chk(timeout_status, off ? 4'h0 : 4'h1 << c);
    chk(timeout_count, off ? 32'h0 : 32'h1 << (8 * c));
    chk(n_msg, m + rep);
    if (rep) chk(msg_t, 2'h2);
    @(negedge clk);
    timeout_count_rd = 4'h1 << c;
    timeout_status_clr = 4'hF;
    @(negedge clk);
    timeout_count_rd = 4'h0;
    timeout_status_clr = 4'h0;
    chk({timeout_count, timeout_status}, 36'h0);
  endtask

  task automatic t_rewrite;
    logic [31:0] h [4] = '{32'h4000_0001, 32'h0400_0001, 32'h0200_0001, 32'h7000_0001};
    int b;
    force_relaxed_ordering = 1'b1;
    relaxed_ordering_value = 1'b1;
    force_no_snoop = 1'b1;
    no_snoop_value = 1'b1;
    slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      b = lk.n;
      send(h[i], 2'h0, 2);
      wait_n(b + 2);
      chk(lk.d[b], (i == 0) ? 32'h4000_3001 : h[i]);
      chk(^{lk.d[b], lk.p[b]}, 1'b0);
      chk({^{lk.d[b + 1], lk.p[b + 1]}, lk.nl[b + 1]}, 2'h0);
    end
    force_relaxed_ordering = 1'b0;
    force_no_snoop = 1'b0;
  endtask

  task automatic t_parity;
    int b = lk.n;
    int m = n_msg;
    force_bad_parity = 1'b1;
    bad_parity_length = 10'h002;
    send(32'h4000_0002, 2'h0, 3);
    send(32'h4000_0001, 2'h0, 2);
    wait_n(b + 5);
    for (int i = 0; i < 3; i++) chk(^{lk.d[b + i], lk.p[b + i]}, 1'b1);
    chk({lk.p[b + 3] ^ ^lk.d[b + 3], lk.nl[b + 4]}, 2'h0);
    chk({lk.nl[b + 2], lk.fl[b + 2]}, 5'h12);
    chk({parity_error_flag, parity_error_counter}, 9'h101);
    chk({n_msg, msg_t}, {m + 1, 2'h2});
    send(32'h4000_0002, 2'h0, 3);
    wait_n(b + 8);
    chk({n_msg, parity_error_counter}, {m + 1, 8'h02});
    @(negedge clk);
    parity_error_counter_rd = 1'b1;
    parity_error_flag_clr = 1'b1;
    @(negedge clk);
    parity_error_counter_rd = 1'b0;
    parity_error_flag_clr = 1'b0;
    chk({parity_error_flag, parity_error_counter}, 9'h0);
    cfg(1'b0, 1'b1);
    send(32'h4000_0002, 2'h0, 3);
    wait_n(b + 11);
    chk({lk.nl[b + 10], parity_error_flag}, 2'h0);
    chk(^{lk.d[b + 10], lk.p[b + 10]}, 1'b1);
    cfg(1'b0, 1'b0);
    in_consume = 1'b1;
    send(32'h4000_0002, 2'h0, 3);
    in_consume = 1'b0;
    wait_n(b + 14);
    chk({lk.fl[b + 11], lk.fl[b + 13], lk.nl[b + 13]}, 9'h18A);
    chk({parity_error_flag, n_msg}, {1'b1, m + 2});
    force_bad_parity = 1'b0;
  endtask

  initial begin
    {srst, hold} = 2'h3;
    {in_valid, in_sop, in_eop, in_bcast, in_consume, cfg_wr, slow} = 7'h0;
    {cfg_timeout_control_bit, cfg_parity_check_disable, force_bad_parity} = 3'h0;
    {force_relaxed_ordering, relaxed_ordering_value, force_no_snoop, no_snoop_value} = 4'h0;
    {system_error_enable, correctable_report_enable, fatal_report_enable} = 3'h0;
    {nonfatal_report_enable, unsupported_req_report_enable} = 2'h2;
    {parity_error_flag_clr, parity_error_counter_rd, timeout_status_clr} = 6'h0;
    timeout_count_rd = 4'h0;
    {in_data, in_class, bad_parity_length} = 44'h0;
    cfg_timeout_report = 8'h82;
    cfg_parity_report = 2'h2;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk({timeout_status, timeout_count, parity_error_flag, parity_error_counter}, 45'h0);
    for (int c = 0; c < 4; c++) t_age(c[1:0], 1'b0, 1'b0);
    t_age(2'h0, 1'b0, 1'b1);
    cfg(1'b1, 1'b0);
    t_age(2'h0, 1'b1, 1'b0);
    cfg(1'b0, 1'b0);
    t_rewrite();
    t_parity();
    finish_test();
  end

  initial begin
    #1000000;
    fails++;
    finish_test();
  end
endmodule // swti_port_integrity_tb_top
